// file: inc/gdc_pkg.sv
// Constants and carrier types for the gate driver configuration register bank.
// Assumes one clock and a synchronous active-high reset shared with the serial link.
package gdc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL1 = 8'h06;
	localparam logic [7:0] OFS_CTRL2 = 8'h07;
	localparam logic [7:0] OFS_STRENGTH = 8'h08;
	localparam logic [7:0] OFS_OCP = 8'h09;
	localparam logic [7:0] OFS_SELA = 8'h0a;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_CTRL1 = 8'h35;
	localparam logic [7:0] RST_CTRL2 = 8'h50;
	localparam logic [7:0] RST_STRENGTH = 8'hff;
	localparam logic [7:0] RST_OCP = 8'h00;
	localparam logic [7:0] RST_SELA = 8'h14;
	localparam logic RST_LOCKED = 1'b0;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_CLEAR = 7;
	localparam int POS_LOCK = 4;
	localparam int POS_MODE = 3;
	localparam int POS_SHUNT_TRIP = 0;
	localparam int POS_DEAD = 6;
	localparam int POS_TRANS = 4;
	localparam int POS_BEMF = 3;
	localparam int POS_DA = 0;
	localparam int POS_UPPER = 4;
	localparam int POS_LOWER = 0;
	localparam int POS_VDS_TRIP = 4;
	localparam int POS_SHUNT_RETRY = 3;
	localparam int POS_VDS_RETRY = 2;
	localparam int POS_FILTER = 0;
	localparam int POS_HYS = 7;
	localparam int POS_UPPER_SRC = 4;
	localparam int POS_UV = 3;
	localparam int POS_LOWER_SRC = 0;
	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;
	localparam logic [2:0] SRC_OFF = 3'h7;
	localparam logic [1:0] RESP_RETRY = 2'h1;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int RETRY_LONG_US = 4000;
	localparam int RETRY_SHORT_US = 70;
	localparam int RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
	localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
	localparam int SLEEP_US = 850;
	localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
	localparam int CNT_W = 20;

	typedef enum logic [1:0] {
		GDC_RUN = 2'b00,
		GDC_WAIT = 2'b01
	} gdc_retry_t;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] strength;
		logic [7:0] ocp;
		logic [7:0] sela;
		logic locked;
		logic clear;
		logic [7:0] rdata;
		logic [1:0] en_sync;
		logic [CNT_W-1:0] en_low_cnt;
		gdc_retry_t shunt_st;
		gdc_retry_t vds_st;
		logic [CNT_W-1:0] shunt_cnt;
		logic [CNT_W-1:0] vds_cnt;
		logic shunt_resume;
		logic vds_resume;
		logic upper_off;
		logic lower_off;
	} gdc_state_t;
endpackage

// file: src/gdc_config_regs.sv
// Configuration register bank with write lock, fault clear and retry timers.
// Assumes the serial link presents one-cycle write/read strobes on CORE_CLK.
`timescale 1ns/1ps
module gdc_config_regs #(
	parameter int RETRY_LONG = gdc_pkg::RETRY_LONG_CYC,
	parameter int RETRY_SHORT = gdc_pkg::RETRY_SHORT_CYC,
	parameter int SLEEP_TIME = gdc_pkg::SLEEP_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic ENABLE_PIN,
	input wire logic [1:0] SHUNT_FAULT_RESPONSE,
	input wire logic [1:0] DRAIN_SOURCE_FAULT_RESPONSE,
	input wire logic SHUNT_TRIP,
	input wire logic VDS_TRIP,
	output logic [7:0] RDATA,
	output logic FAULT_CLEAR_PULSE,
	output logic WRITE_LOCKED,
	output logic INPUT_DRIVE_STYLE,
	output logic [2:0] SHUNT_TRIP_LEVEL,
	output logic [1:0] DEAD_TIME_SEL,
	output logic [1:0] MAX_SWITCH_TRANSITION,
	output logic BACK_EMF_AMP_ON,
	output logic [2:0] DIFF_AMP_ON,
	output logic [3:0] UPPER_DRIVE_STRENGTH,
	output logic [3:0] LOWER_DRIVE_STRENGTH,
	output logic [4:0] UPPER_SINK_STRENGTH,
	output logic [4:0] LOWER_SINK_STRENGTH,
	output logic [3:0] DRAIN_SOURCE_TRIP_LEVEL,
	output logic SHUNT_RETRY_WAIT,
	output logic DRAIN_SOURCE_RETRY_WAIT,
	output logic [1:0] OVERCURRENT_FILTER_TIME,
	output logic COMPARATOR_ONE_HYSTERESIS,
	output logic SUPPLY_LOW_TRIP_LEVEL,
	output logic [2:0] PHASE_A_UPPER_SOURCE,
	output logic [2:0] PHASE_A_LOWER_SOURCE,
	output logic PHASE_A_UPPER_OFF,
	output logic PHASE_A_LOWER_OFF,
	output logic SHUNT_RESUME,
	output logic VDS_RESUME
);
	gdc_pkg::gdc_state_t s;
	gdc_pkg::gdc_state_t next_s;
	logic wr_ok;
	logic [2:0] wlock;
	logic en_low_long;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		wlock = WDATA[gdc_pkg::POS_LOCK +: 3];
		wr_ok = WR_EN && !s.locked;
		next_s.clear = 1'b0;
		next_s.shunt_resume = 1'b0;
		next_s.vds_resume = 1'b0;
		// Lock field is always writable so software can unlock
		if (WR_EN && ADDR == gdc_pkg::OFS_CTRL1)
		begin
			if (wlock == gdc_pkg::LOCK_CODE)
				next_s.locked = 1'b1;
			else if (wlock == gdc_pkg::UNLOCK_CODE)
				next_s.locked = 1'b0;
			// Other codes leave the lock as is
			next_s.ctrl1[gdc_pkg::POS_LOCK +: 3] = wlock;
		end
		if (wr_ok && ADDR == gdc_pkg::OFS_CTRL1)
		begin
			next_s.ctrl1[gdc_pkg::POS_MODE:0] = WDATA[gdc_pkg::POS_MODE:0];
			next_s.clear = WDATA[gdc_pkg::POS_CLEAR];
		end
		else if (wr_ok && ADDR == gdc_pkg::OFS_CTRL2)
			next_s.ctrl2 = WDATA;
		else if (wr_ok && ADDR == gdc_pkg::OFS_STRENGTH)
			next_s.strength = WDATA;
		else if (wr_ok && ADDR == gdc_pkg::OFS_OCP)
			next_s.ocp = WDATA;
		else if (wr_ok && ADDR == gdc_pkg::OFS_SELA)
			next_s.sela = WDATA;
		// Off flags are registered so the driver stage sees them straight from a flop
		next_s.upper_off = next_s.sela[gdc_pkg::POS_UPPER_SRC +: 3] == gdc_pkg::SRC_OFF;
		next_s.lower_off = next_s.sela[gdc_pkg::POS_LOWER_SRC +: 3] == gdc_pkg::SRC_OFF;
		// Stored clear bit never held
		next_s.ctrl1[gdc_pkg::POS_CLEAR] = 1'b0;
		// Long enable-low pulse is a second fault clear path
		next_s.en_sync = {s.en_sync[0], ENABLE_PIN};
		en_low_long = 1'b0;
		if (s.en_sync[1])
			next_s.en_low_cnt = '0;
		else if (s.en_low_cnt < gdc_pkg::CNT_W'(SLEEP_TIME))
			next_s.en_low_cnt = s.en_low_cnt + 1'b1;
		else
			en_low_long = 1'b1;
		if (en_low_long && s.en_low_cnt == gdc_pkg::CNT_W'(SLEEP_TIME)
			&& s.en_sync[1] == 1'b0 && !s.clear)
			next_s.clear = 1'b1;
		if (en_low_long)
			next_s.en_low_cnt = s.en_low_cnt + 1'b1;
		if (s.en_low_cnt == {gdc_pkg::CNT_W{1'b1}})
			next_s.en_low_cnt = s.en_low_cnt;
		// Retry timers run only in automatic retry mode
		case (s.shunt_st)
			gdc_pkg::GDC_RUN:
			begin
				if (SHUNT_TRIP && SHUNT_FAULT_RESPONSE == gdc_pkg::RESP_RETRY)
				begin
					next_s.shunt_st = gdc_pkg::GDC_WAIT;
					next_s.shunt_cnt = s.ocp[gdc_pkg::POS_SHUNT_RETRY] ?
						gdc_pkg::CNT_W'(RETRY_SHORT - 1) : gdc_pkg::CNT_W'(RETRY_LONG - 1);
				end
			end
			default:
			begin
				if (SHUNT_FAULT_RESPONSE != gdc_pkg::RESP_RETRY)
					next_s.shunt_st = gdc_pkg::GDC_RUN;
				else if (s.shunt_cnt == '0)
				begin
					next_s.shunt_st = gdc_pkg::GDC_RUN;
					next_s.shunt_resume = 1'b1;
				end
				else
					next_s.shunt_cnt = s.shunt_cnt - 1'b1;
			end
		endcase
		case (s.vds_st)
			gdc_pkg::GDC_RUN:
			begin
				if (VDS_TRIP && DRAIN_SOURCE_FAULT_RESPONSE == gdc_pkg::RESP_RETRY)
				begin
					next_s.vds_st = gdc_pkg::GDC_WAIT;
					next_s.vds_cnt = s.ocp[gdc_pkg::POS_VDS_RETRY] ?
						gdc_pkg::CNT_W'(RETRY_SHORT - 1) : gdc_pkg::CNT_W'(RETRY_LONG - 1);
				end
			end
			default:
			begin
				if (DRAIN_SOURCE_FAULT_RESPONSE != gdc_pkg::RESP_RETRY)
					next_s.vds_st = gdc_pkg::GDC_RUN;
				else if (s.vds_cnt == '0)
				begin
					next_s.vds_st = gdc_pkg::GDC_RUN;
					next_s.vds_resume = 1'b1;
				end
				else
					next_s.vds_cnt = s.vds_cnt - 1'b1;
			end
		endcase
		// Reads return stored contents even while locked
		if (RD_EN)
		begin
			if (ADDR == gdc_pkg::OFS_CTRL1)
				next_s.rdata = s.ctrl1;
			else if (ADDR == gdc_pkg::OFS_CTRL2)
				next_s.rdata = s.ctrl2;
			else if (ADDR == gdc_pkg::OFS_STRENGTH)
				next_s.rdata = s.strength;
			else if (ADDR == gdc_pkg::OFS_OCP)
				next_s.rdata = s.ocp;
			else if (ADDR == gdc_pkg::OFS_SELA)
				next_s.rdata = s.sela;
			else
				next_s.rdata = 8'h00;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			s <= '0;
			s.ctrl1 <= gdc_pkg::RST_CTRL1;
			s.ctrl2 <= gdc_pkg::RST_CTRL2;
			s.strength <= gdc_pkg::RST_STRENGTH;
			s.ocp <= gdc_pkg::RST_OCP;
			s.sela <= gdc_pkg::RST_SELA;
			s.locked <= gdc_pkg::RST_LOCKED;
			s.en_sync <= 2'h3;
			s.shunt_st <= gdc_pkg::GDC_RUN;
			s.vds_st <= gdc_pkg::GDC_RUN;
		end
		else
			s <= next_s;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Sink code is source code shifted left, i.e. twice the current
	assign RDATA = s.rdata;
	assign FAULT_CLEAR_PULSE = s.clear;
	assign WRITE_LOCKED = s.locked;
	assign INPUT_DRIVE_STYLE = s.ctrl1[gdc_pkg::POS_MODE];
	assign SHUNT_TRIP_LEVEL = s.ctrl1[gdc_pkg::POS_SHUNT_TRIP +: 3];
	assign DEAD_TIME_SEL = s.ctrl2[gdc_pkg::POS_DEAD +: 2];
	assign MAX_SWITCH_TRANSITION = s.ctrl2[gdc_pkg::POS_TRANS +: 2];
	assign BACK_EMF_AMP_ON = s.ctrl2[gdc_pkg::POS_BEMF];
	assign DIFF_AMP_ON = s.ctrl2[gdc_pkg::POS_DA +: 3];
	assign UPPER_DRIVE_STRENGTH = s.strength[gdc_pkg::POS_UPPER +: 4];
	assign LOWER_DRIVE_STRENGTH = s.strength[gdc_pkg::POS_LOWER +: 4];
	assign UPPER_SINK_STRENGTH = {s.strength[gdc_pkg::POS_UPPER +: 4], 1'b0};
	assign LOWER_SINK_STRENGTH = {s.strength[gdc_pkg::POS_LOWER +: 4], 1'b0};
	assign DRAIN_SOURCE_TRIP_LEVEL = s.ocp[gdc_pkg::POS_VDS_TRIP +: 4];
	assign SHUNT_RETRY_WAIT = s.ocp[gdc_pkg::POS_SHUNT_RETRY];
	assign DRAIN_SOURCE_RETRY_WAIT = s.ocp[gdc_pkg::POS_VDS_RETRY];
	assign OVERCURRENT_FILTER_TIME = s.ocp[gdc_pkg::POS_FILTER +: 2];
	assign COMPARATOR_ONE_HYSTERESIS = s.sela[gdc_pkg::POS_HYS];
	assign SUPPLY_LOW_TRIP_LEVEL = s.sela[gdc_pkg::POS_UV];
	assign PHASE_A_UPPER_SOURCE = s.sela[gdc_pkg::POS_UPPER_SRC +: 3];
	assign PHASE_A_LOWER_SOURCE = s.sela[gdc_pkg::POS_LOWER_SRC +: 3];
	assign PHASE_A_UPPER_OFF = s.upper_off;
	assign PHASE_A_LOWER_OFF = s.lower_off;
	assign SHUNT_RESUME = s.shunt_resume;
	assign VDS_RESUME = s.vds_resume;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_clear_pulse: assert property (WR_EN && !s.locked && ADDR == gdc_pkg::OFS_CTRL1
		&& WDATA[7] |=> FAULT_CLEAR_PULSE) else $error("clear write gave no pulse");
	a_clear_once: assert property (FAULT_CLEAR_PULSE && !(WR_EN && WDATA[7])
		&& s.en_sync[1] |=> !FAULT_CLEAR_PULSE) else $error("clear pulse held");
	a_lock_sets: assert property (WR_EN && ADDR == gdc_pkg::OFS_CTRL1
		&& WDATA[6:4] == gdc_pkg::LOCK_CODE |=> WRITE_LOCKED) else $error("lock missed");
	a_unlock_clears: assert property (WR_EN && ADDR == gdc_pkg::OFS_CTRL1
		&& WDATA[6:4] == gdc_pkg::UNLOCK_CODE |=> !WRITE_LOCKED) else $error("unlock missed");
	a_lock_holds: assert property (!(WR_EN && ADDR == gdc_pkg::OFS_CTRL1
		&& (WDATA[6:4] == gdc_pkg::LOCK_CODE || WDATA[6:4] == gdc_pkg::UNLOCK_CODE))
		|=> $stable(WRITE_LOCKED)) else $error("lock changed");
	a_locked_frozen: assert property (WRITE_LOCKED && WR_EN
		|=> $stable(s.ctrl2) && $stable(s.strength) && $stable(s.ocp) && $stable(s.sela))
		else $error("locked write stored");
	a_sink_double: assert property (WR_EN && !WRITE_LOCKED && ADDR == gdc_pkg::OFS_STRENGTH
		|=> UPPER_SINK_STRENGTH == 5'($past(WDATA[7:4])) * 5'h02
		&& LOWER_SINK_STRENGTH == 5'($past(WDATA[3:0])) * 5'h02) else $error("sink not 2x");
	a_off_code: assert property (WR_EN && !WRITE_LOCKED && ADDR == gdc_pkg::OFS_SELA
		|=> PHASE_A_UPPER_OFF == ($past(WDATA[6:4]) == gdc_pkg::SRC_OFF)
		&& PHASE_A_LOWER_OFF == ($past(WDATA[2:0]) == gdc_pkg::SRC_OFF))
		else $error("off flag wrong");
	a_clear_reads0: assert property (RD_EN && ADDR == gdc_pkg::OFS_CTRL1
		|=> !RDATA[7]) else $error("clear bit read as one");
	a_retry_mode: assert property (SHUNT_FAULT_RESPONSE != gdc_pkg::RESP_RETRY
		|=> !SHUNT_RESUME) else $error("resume outside retry");

	c_lock_then_write: cover property (WRITE_LOCKED && WR_EN && ADDR == gdc_pkg::OFS_CTRL2);
	c_clear_write: cover property (FAULT_CLEAR_PULSE);
	c_shunt_resume: cover property (SHUNT_RESUME);
	c_vds_resume: cover property (VDS_RESUME);
endmodule // gdc_config_regs

// file: test/gdc_mcu_model.sv
// Model of the co-packaged controller: drives the register strobes of the bank.
// Assumes the bank samples one-cycle strobes on the rising clock edge.
`timescale 1ns/1ps
module gdc_mcu_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// Released lines show the inverse, so a late sample never sees stale values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		#1 d = rdata;
	endtask
endmodule // gdc_mcu_model

// file: test/gdc_config_regs_bench.sv
// Self-checking bench for the configuration register bank.
// Assumes the controller model on the register strobes; fault side driven here.
`timescale 1ns/1ps
module gdc_config_regs_bench;
	logic clk, rst, wr_en, rd_en, en_pin, s_trip, v_trip;
	logic [7:0] addr, wdata, rdata, rv;
	logic [1:0] s_mode, v_mode;
	logic clr, lck, style, u_off, l_off, s_res, v_res, bemf, hys, uv, sw, vw;
	logic [2:0] s_lvl, dif, u_src, l_src;
	logic [1:0] dead, trans, filt;
	logic [3:0] u_str, l_str, v_lvl;
	logic [4:0] u_snk, l_snk;
	int error_cnt = 0;
	int checks = 0;
	logic [7:0] ra [5] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
	logic [7:0] rst_v [5] = '{8'h35, 8'h50, 8'hff, 8'h00, 8'h14};

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	gdc_mcu_model u_mcu (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata));
	gdc_config_regs #(.RETRY_LONG(20), .RETRY_SHORT(5), .SLEEP_TIME(10)) u_dut (
		.CORE_CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
		.WDATA(wdata), .ENABLE_PIN(en_pin), .SHUNT_FAULT_RESPONSE(s_mode),
		.DRAIN_SOURCE_FAULT_RESPONSE(v_mode), .SHUNT_TRIP(s_trip), .VDS_TRIP(v_trip),
		.RDATA(rdata), .FAULT_CLEAR_PULSE(clr), .WRITE_LOCKED(lck),
		.INPUT_DRIVE_STYLE(style), .SHUNT_TRIP_LEVEL(s_lvl), .DEAD_TIME_SEL(dead),
		.MAX_SWITCH_TRANSITION(trans), .BACK_EMF_AMP_ON(bemf), .DIFF_AMP_ON(dif),
		.UPPER_DRIVE_STRENGTH(u_str), .LOWER_DRIVE_STRENGTH(l_str),
		.UPPER_SINK_STRENGTH(u_snk), .LOWER_SINK_STRENGTH(l_snk),
		.DRAIN_SOURCE_TRIP_LEVEL(v_lvl), .SHUNT_RETRY_WAIT(sw),
		.DRAIN_SOURCE_RETRY_WAIT(vw), .OVERCURRENT_FILTER_TIME(filt),
		.COMPARATOR_ONE_HYSTERESIS(hys), .SUPPLY_LOW_TRIP_LEVEL(uv),
		.PHASE_A_UPPER_SOURCE(u_src), .PHASE_A_LOWER_SOURCE(l_src),
		.PHASE_A_UPPER_OFF(u_off), .PHASE_A_LOWER_OFF(l_off),
		.SHUNT_RESUME(s_res), .VDS_RESUME(v_res));

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Trip one detector; with on set, resume must follow within n-1 to n+2 cycles, with on clear it must not come in that window
	task automatic retry(input bit vds, input int n, input bit on);
		int c;
		c = 0;
		@(posedge clk);
		s_trip <= !vds;
		v_trip <= vds;
		@(posedge clk);
		s_trip <= 1'b0;
		v_trip <= 1'b0;
		while (c < 40 && !(vds ? v_res : s_res))
		begin
			@(posedge clk);
			#1 c++;
		end
		chk("resume", {7'h00, on}, {7'h00, c >= n - 1 && c <= n + 2});
		repeat (3) @(posedge clk);
	endtask
	// Pin low for exactly n edges, then watch the pulse count a while longer
	task automatic en_low(input int n, input logic [7:0] e);
		logic [7:0] p;
		p = 8'h00;
		@(posedge clk);
		en_pin <= 1'b0;
		for (int i = 0; i < n + 8; i++)
		begin
			@(posedge clk);
			if (i == n - 1)
				en_pin <= 1'b1;
			#1;
			if (clr === 1'b1)
				p = p + 8'h01;
			else if (clr !== 1'b0)
				p = 8'hff;
		end
		chk("enable_clear", e, p);
		repeat (4) @(posedge clk);
	endtask

	initial
	begin
		rst = 1'b1;
		en_pin = 1'b1;
		s_mode = 2'h1;
		v_mode = 2'h1;
		s_trip = 1'b0;
		v_trip = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			u_mcu.rd(ra[i], rv);
			chk("reset_value", rst_v[i], rv);
		end
		u_mcu.rd(8'h20, rv);
		chk("unmapped", 8'h00, rv);
		$display("test reset done");
		u_mcu.wr(8'h06, 8'hb5);
		#1 chk("clear_pulse", 8'h01, {7'h00, clr});
		@(posedge clk);
		#1 chk("clear_drop", 8'h00, {7'h00, clr});
		u_mcu.rd(8'h06, rv);
		chk("clear_read", 8'h35, rv);
		$display("test clear done");
		u_mcu.wr(8'h06, 8'h68);
		#1 chk("locked", 8'h01, {7'h00, lck});
		chk("style", 8'h01, {7'h00, style});
		chk("shunt_trip", 8'h00, {5'h00, s_lvl});
		u_mcu.wr(8'h07, 8'hff);
		u_mcu.rd(8'h07, rv);
		chk("locked_write", 8'h50, rv);
		u_mcu.wr(8'h06, 8'h97);
		#1 chk("clear_locked", 8'h00, {7'h00, clr});
		chk("other_code", 8'h01, {7'h00, lck});
		u_mcu.wr(8'h06, 8'h30);
		#1 chk("unlocked", 8'h00, {7'h00, lck});
		$display("test lock done");
		u_mcu.wr(8'h07, 8'ha6);
		u_mcu.wr(8'h08, 8'h3c);
		u_mcu.wr(8'h09, 8'h9e);
		u_mcu.wr(8'h0a, 8'hf9);
		u_mcu.rd(8'h07, rv);
		chk("ctrl2", 8'ha6, rv);
		chk("time_fields", 8'h0a, {4'h0, dead, trans});
		chk("amps", 8'h06, {4'h0, bemf, dif});
		chk("strength", 8'h3c, {u_str, l_str});
		chk("sinks", 8'h06, {3'h0, u_snk});
		chk("sinkl", 8'h18, {3'h0, l_snk});
		chk("ocp", 8'h9e, {v_lvl, sw, vw, filt});
		chk("sela", 8'hf9, {hys, u_src, uv, l_src});
		chk("off", 8'h02, {6'h00, u_off, l_off});
		$display("test fields done");
		retry(1'b0, 5, 1'b1);
		retry(1'b1, 5, 1'b1);
		u_mcu.wr(8'h09, 8'h90);
		retry(1'b0, 20, 1'b1);
		retry(1'b1, 20, 1'b1);
		s_mode <= 2'h0;
		v_mode <= 2'h2;
		retry(1'b0, 20, 1'b0);
		retry(1'b1, 20, 1'b0);
		$display("test retry done");
		en_low(4, 8'h00);
		en_low(14, 8'h01);
		$display("test enable done");
		u_mcu.wr(8'h06, 8'h60);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk("reset_unlock", 8'h00, {7'h00, lck});
		u_mcu.rd(8'h06, rv);
		chk("reset_ctrl1", 8'h35, rv);
		u_mcu.rd(8'h07, rv);
		chk("reset_ctrl2", 8'h50, rv);
		$display("test midrun reset done");
		tally_and_finish();
	end
	initial
	begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule // gdc_config_regs_bench
